// ===== logic/ccp_pkg.sv
// Package for the capture/compare/PWM channel: register map, field layout, modes.
// Assumes an APB master with 32-bit data and word-aligned registers.
package ccp_pkg;
    localparam logic [11:0] OFS_CONTROL  = 12'h000;
    localparam logic [11:0] OFS_PAIR     = 12'h004;
    localparam logic [11:0] OFS_SOURCE   = 12'h008;
    localparam logic [11:0] OFS_FLAG     = 12'h00c;
    localparam logic [11:0] OFS_PERIOD   = 12'h010;

    localparam int          CTL_MODE_LSB = 0;
    localparam int          CTL_FMT_BIT  = 4;
    localparam int          CTL_OUT_BIT  = 5;
    localparam int          CTL_EN_BIT   = 7;
    localparam logic [7:0]  CTL_RESET    = 8'h00;
    localparam logic [7:0]  PERIOD_RESET = 8'hff;
    localparam logic [3:0]  PRESC_FOUR   = 4'h3;
    localparam logic [3:0]  PRESC_SIXTEEN = 4'hf;
    localparam int          SOURCE_COUNT = 9;

    typedef enum logic [3:0] {
        MODE_OFF        = 4'b0000,
        MODE_CMP_TOGGLE_CLR = 4'b0001,
        MODE_CMP_TOGGLE = 4'b0010,
        MODE_CAP_ANY    = 4'b0011,
        MODE_CAP_FALL   = 4'b0100,
        MODE_CAP_RISE   = 4'b0101,
        MODE_CAP_RISE4  = 4'b0110,
        MODE_CAP_RISE16 = 4'b0111,
        MODE_CMP_SET    = 4'b1000,
        MODE_CMP_CLEAR  = 4'b1001,
        MODE_CMP_PULSE  = 4'b1010,
        MODE_CMP_PULSE2 = 4'b1011,
        MODE_PWM        = 4'b1100,
        MODE_PWM_ALT    = 4'b1101,
        MODE_PWM_ALT2   = 4'b1110,
        MODE_PWM_ALT3   = 4'b1111
    } channel_mode_t;

    typedef struct packed {
        logic [SOURCE_COUNT-1:0] sources;
        logic                    pinLevel;
    } capture_inputs_t;

    typedef struct packed {
        logic [15:0] captureCount;
        logic [15:0] compareCount;
        logic [7:0]  periodCount;
        logic [1:0]  periodFine;
        logic        periodTick;
    } timer_inputs_t;
endpackage : ccp_pkg

// ===== logic/edge_sync.sv
// Two-stage synchroniser with rise and fall pulses on the synchronised level.
// Assumes its input may change at any time relative to ref_clk.
`timescale 1ns/1ns
`default_nettype none
module edge_sync (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic asyncIn,
    output logic      rise,
    output logic      fall
);
    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic stage1_next;
    logic stage2_next;
    logic stage3_next;

    always_comb
    begin
        stage1_next = asyncIn;
        stage2_next = stage1_reg;
        stage3_next = stage2_reg;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            stage1_reg <= 1'b0;
            stage2_reg <= 1'b0;
            stage3_reg <= 1'b0;
        end
        else
        begin
            stage1_reg <= stage1_next;
            stage2_reg <= stage2_next;
            stage3_reg <= stage3_next;
        end
    end

    // Edges are judged on the second and third stages only, never the first.
    assign rise = stage2_reg & ~stage3_reg;
    assign fall = ~stage2_reg & stage3_reg;
endmodule : edge_sync
`default_nettype wire

// ===== logic/capture_compare_pwm_unit.sv
// One capture/compare/PWM channel with an APB register slave.
// Assumes external timers supply counts and the period timer its tick and fine bits.
`timescale 1ns/1ns
`default_nettype none
module capture_compare_pwm_unit (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [11:0]              paddr,
    input  wire logic [31:0]              pwdata,
    output logic                          pready,
    output logic [31:0]                   prdata,
    output logic                          pslverr,
    input  wire ccp_pkg::capture_inputs_t capIn,
    input  wire ccp_pkg::timer_inputs_t   timers,
    input  wire logic                     triggerSelected,
    input  wire logic                     channel_event_enable,
    output logic                          channel_event_flag,
    output logic                          conversionTrigger,
    output logic                          timerResetRequest,
    output logic                          wakeRequest,
    output logic                          channelOut
);
    import ccp_pkg::*;

    logic [7:0]  ctl_reg;
    logic [7:0]  ctl_next;
    logic [15:0] pair_reg;
    logic [15:0] pair_next;
    logic [3:0]  srcSel_reg;
    logic [3:0]  srcSel_next;
    logic [7:0]  period_reg;
    logic [7:0]  period_next;
    logic        flag_reg;
    logic        flag_next;
    logic [3:0]  presc_reg;
    logic [3:0]  presc_next;
    logic        outLatch_reg;
    logic        outLatch_next;
    logic        matchSeen_reg;
    logic        matchSeen_next;
    logic        trig_reg;
    logic        trig_next;
    logic        tmrRst_reg;
    logic        tmrRst_next;
    logic [9:0]  dutyBuf_reg;
    logic [9:0]  dutyBuf_next;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;

    channel_mode_t mode;
    logic          enabled;
    logic          isCapture;
    logic          isCompare;
    logic          isPwm;
    logic          srcLevel;
    logic          srcRise;
    logic          srcFall;
    logic          captureEvent;
    logic          match;
    logic          matchEdge;
    logic          access;
    logic          wrAccess;
    logic          mapped;
    logic [9:0]    dutyValue;
    logic [9:0]    timeBase;

    assign mode      = channel_mode_t'(ctl_reg[CTL_MODE_LSB +: 4]);
    assign enabled   = ctl_reg[CTL_EN_BIT];
    assign isCapture = enabled && (mode inside {MODE_CAP_ANY, MODE_CAP_FALL, MODE_CAP_RISE,
                                                MODE_CAP_RISE4, MODE_CAP_RISE16});
    assign isPwm     = enabled && (mode inside {MODE_PWM, MODE_PWM_ALT, MODE_PWM_ALT2,
                                                MODE_PWM_ALT3});
    assign isCompare = enabled && !isCapture && !isPwm && (mode != MODE_OFF);

    // Index 0 is the pin itself, read back from the pad so port writes still capture.
    always_comb
    begin
        srcLevel = 1'b0;
        if (srcSel_reg == 4'h0)
            srcLevel = capIn.pinLevel;
        else if (srcSel_reg < 4'(SOURCE_COUNT))
            srcLevel = capIn.sources[srcSel_reg];
    end

    edge_sync u_sync (
        .ref_clk (ref_clk),
        .sys_rst (sys_rst),
        .asyncIn (srcLevel),
        .rise    (srcRise),
        .fall    (srcFall)
    );

    always_comb
    begin
        captureEvent = 1'b0;
        presc_next   = presc_reg;
        if (!isCapture)
            presc_next = 4'h0;
        else
        begin
            case (mode)
                MODE_CAP_ANY:    captureEvent = srcRise | srcFall;
                MODE_CAP_FALL:   captureEvent = srcFall;
                MODE_CAP_RISE:   captureEvent = srcRise;
                MODE_CAP_RISE4:
                begin
                    // Switching prescales keeps the count, so a stale count may fire early.
                    if (srcRise)
                    begin
                        captureEvent = (presc_reg >= PRESC_FOUR);
                        presc_next   = captureEvent ? 4'h0 : presc_reg + 4'h1;
                    end
                end
                MODE_CAP_RISE16:
                begin
                    if (srcRise)
                    begin
                        captureEvent = (presc_reg == PRESC_SIXTEEN);
                        presc_next   = captureEvent ? 4'h0 : presc_reg + 4'h1;
                    end
                end
                default:         captureEvent = 1'b0;
            endcase
        end
    end

    assign match     = isCompare && (pair_reg == timers.compareCount);
    assign matchEdge = match && !matchSeen_reg;
    assign dutyValue = ctl_reg[CTL_FMT_BIT] ? pair_reg[15:6] : pair_reg[9:0];
    assign timeBase  = {timers.periodCount, timers.periodFine};

    assign access   = psel && penable;
    assign wrAccess = access && pwrite;
    assign mapped   = paddr inside {OFS_CONTROL, OFS_PAIR, OFS_SOURCE, OFS_FLAG, OFS_PERIOD};

    always_comb
    begin
        ctl_next       = ctl_reg;
        pair_next      = pair_reg;
        srcSel_next    = srcSel_reg;
        period_next    = period_reg;
        flag_next      = flag_reg;
        outLatch_next  = outLatch_reg;
        matchSeen_next = match;
        trig_next      = 1'b0;
        tmrRst_next    = 1'b0;
        dutyBuf_next   = dutyBuf_reg;
        rdata_next     = rdata_reg;

        if (wrAccess)
        begin
            case (paddr)
                OFS_CONTROL: ctl_next    = pwdata[7:0];
                OFS_PAIR:    pair_next   = pwdata[15:0];
                OFS_SOURCE:  srcSel_next = pwdata[3:0];
                OFS_FLAG:    flag_next   = flag_reg & ~pwdata[0];
                OFS_PERIOD:  period_next = pwdata[7:0];
                default:     ctl_next    = ctl_reg;
            endcase
        end
        if (access && !pwrite)
        begin
            case (paddr)
                OFS_CONTROL: rdata_next = {24'h0, ctl_reg[7:6], outLatch_reg, ctl_reg[4:0]};
                OFS_PAIR:    rdata_next = {16'h0, pair_reg};
                OFS_SOURCE:  rdata_next = {28'h0, srcSel_reg};
                OFS_FLAG:    rdata_next = {31'h0, flag_reg};
                OFS_PERIOD:  rdata_next = {24'h0, period_reg};
                default:     rdata_next = 32'h0;
            endcase
        end

        // A hardware set lands after the software clear so a coincident event is kept.
        if (captureEvent)
        begin
            pair_next = timers.captureCount;
            flag_next = 1'b1;
        end

        if (matchEdge)
        begin
            flag_next = 1'b1;
            trig_next = triggerSelected;
            case (mode)
                MODE_CMP_TOGGLE,
                MODE_CMP_TOGGLE_CLR: outLatch_next = ~outLatch_reg;
                MODE_CMP_SET:        outLatch_next = 1'b1;
                MODE_CMP_CLEAR:      outLatch_next = 1'b0;
                default:             outLatch_next = outLatch_reg;
            endcase
        end
        // Timer reset follows the trigger edge only if the match still holds.
        if (trig_reg && match && mode == MODE_CMP_TOGGLE_CLR)
            tmrRst_next = 1'b1;

        // The fine bits advance every cycle, so the duty match is checked on every cycle.
        if (isPwm)
        begin
            if (timers.periodTick && timers.periodCount == period_reg)
            begin
                dutyBuf_next  = dutyValue;
                outLatch_next = (dutyValue != 10'h000);
            end
            else if (timeBase == dutyBuf_reg)
                outLatch_next = 1'b0;
        end

        // Clearing control wins over any match or PWM change to the latch in the same cycle.
        if (wrAccess && paddr == OFS_CONTROL && pwdata[7:0] == CTL_RESET)
            outLatch_next = 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
        begin
            ctl_reg       <= CTL_RESET;
            pair_reg      <= 16'h0000;
            srcSel_reg    <= 4'h0;
            period_reg    <= PERIOD_RESET;
            flag_reg      <= 1'b0;
            presc_reg     <= 4'h0;
            outLatch_reg  <= 1'b0;
            matchSeen_reg <= 1'b0;
            trig_reg      <= 1'b0;
            tmrRst_reg    <= 1'b0;
            dutyBuf_reg   <= 10'h000;
            rdata_reg     <= 32'h0;
        end
        else
        begin
            ctl_reg       <= ctl_next;
            pair_reg      <= pair_next;
            srcSel_reg    <= srcSel_next;
            period_reg    <= period_next;
            flag_reg      <= flag_next;
            presc_reg     <= presc_next;
            outLatch_reg  <= outLatch_next;
            matchSeen_reg <= matchSeen_next;
            trig_reg      <= trig_next;
            tmrRst_reg    <= tmrRst_next;
            dutyBuf_reg   <= dutyBuf_next;
            rdata_reg     <= rdata_next;
        end
    end

    // Writes are zero-wait, answered in the access cycle; read data is registered one cycle later,
    // so reads insert one wait state to present registered data.
    logic rdWait_reg;
    logic rdWait_next;
    assign rdWait_next = access && !pwrite && !rdWait_reg;
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            rdWait_reg <= 1'b0;
        else
            rdWait_reg <= rdWait_next;
    end

    assign pready             = pwrite ? 1'b1 : rdWait_reg;
    assign prdata             = rdata_reg;
    assign pslverr            = access && pready && !mapped;
    assign channel_event_flag = flag_reg;
    assign conversionTrigger  = trig_reg;
    assign timerResetRequest  = tmrRst_reg;
    assign wakeRequest        = flag_reg && channel_event_enable;
    assign channelOut         = outLatch_reg;
endmodule : capture_compare_pwm_unit
`default_nettype wire

// ===== tb/ccp_asserts.sv
// Checker for one capture/compare/PWM channel, bound to its top module.
// Assumes the compare timer is held still while a match stands.
`timescale 1ns/1ns
`default_nettype none
module ccp_asserts (
    input wire logic                   ref_clk,
    input wire logic                   sys_rst,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic                   pready,
    input wire ccp_pkg::timer_inputs_t timers,
    input wire logic                   triggerSelected,
    input wire logic                   channel_event_enable,
    input wire logic                   channel_event_flag,
    input wire logic                   conversionTrigger,
    input wire logic                   timerResetRequest,
    input wire logic                   wakeRequest,
    input wire logic                   channelOut
);
    import ccp_pkg::*;
    logic        wrCycle;
    logic        flagClear;
    logic        controlZero;
    logic [15:0] pairShadow;
    assign wrCycle     = psel && penable && pwrite;
    assign flagClear   = wrCycle && paddr == OFS_FLAG && pwdata[0];
    assign controlZero = wrCycle && paddr == OFS_CONTROL && pwdata[7:0] == 8'h00;
    // Software writes are the only source of the pair while no capture runs.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst)
            pairShadow <= 16'h0000;
        else if (wrCycle && paddr == OFS_PAIR)
            pairShadow <= pwdata[15:0];
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);
    flag_sticky_a: assert property ($fell(channel_event_flag) && !$past(sys_rst)
        |-> $past(flagClear)) else $error("flag fell without a clear");
    trigger_flag_a: assert property (conversionTrigger
        |-> channel_event_flag && $past(triggerSelected)) else $error("trigger without flag");
    match_value_a: assert property ($rose(conversionTrigger)
        |-> $past(timers.compareCount) == pairShadow) else $error("trigger without match");
    reset_hold_a: assert property (timerResetRequest
        |-> $past(timers.compareCount) == pairShadow) else $error("reset after match gone");
    wake_out_a: assert property (wakeRequest == (channel_event_flag && channel_event_enable))
        else $error("wake differs from flag and enable");
    latch_clear_a: assert property (controlZero |=> !channelOut)
        else $error("latch high after control cleared");
    write_ready_a: assert property (wrCycle |-> pready) else $error("write waited");
    read_wait_a: assert property (psel && $rose(penable) && !pwrite |-> !pready ##1 pready)
        else $error("read answer not on second access cycle");
    cover property ($rose(channel_event_flag));
    cover property (timerResetRequest);
    cover property ($fell(channelOut));
endmodule : ccp_asserts
bind capture_compare_pwm_unit ccp_asserts ccpChecks (.*);
`default_nettype wire

// ===== tb/timer_source_model.sv
// Model of the timers that feed the channel: wide counts and period timer.
// Assumes the bench preloads the counts or stops them between tests.
`timescale 1ns/1ns
`default_nettype none
module timer_source_model (
    input  wire logic                  ref_clk,
    input  wire logic                  sys_rst,
    input  wire logic                  run,
    input  wire logic                  load,
    input  wire logic [15:0]           loadValue,
    input  wire logic [7:0]            periodValue,
    output var ccp_pkg::timer_inputs_t timers
);
    import ccp_pkg::*;
    // Stopping the counts lets a capture be checked against one exact value.
    always_ff @(posedge ref_clk)
    begin
        if (sys_rst || load)
            timers <= {loadValue, loadValue, 11'h000};
        else if (run)
        begin
            timers.captureCount <= timers.captureCount + 16'h0001;
            timers.compareCount <= timers.compareCount + 16'h0001;
            timers.periodFine   <= timers.periodFine + 2'h1;
            timers.periodTick   <= timers.periodFine == 2'h2;
            if (timers.periodTick)
                timers.periodCount <= (timers.periodCount == periodValue) ? 8'h00
                    : timers.periodCount + 8'h01;
        end
        else
            timers.periodTick <= 1'b0;
    end
endmodule : timer_source_model
`default_nettype wire

// ===== tb/test_capture_compare_pwm_unit.sv
// Self-checking bench for one capture/compare/PWM channel over APB.
// Assumes the timer model is stopped or preloaded so counts are exact.
`timescale 1ns/1ns
`default_nettype none
module test_capture_compare_pwm_unit;
    import ccp_pkg::*;
    logic            ref_clk = 1'b0;
    logic            sys_rst, psel, penable, pwrite, pready, pslverr, err, run, load;
    logic            triggerSelected, channel_event_enable, channel_event_flag;
    logic            conversionTrigger, timerResetRequest, wakeRequest, channelOut;
    logic [11:0]     paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic [15:0]     loadValue;
    logic [7:0]      periodValue;
    logic [9:0]      capLines;
    capture_inputs_t capIn;
    timer_inputs_t   timers;
    int              failures = 0;
    int              n_compared = 0;
    int              highs;
    assign capIn = capLines;
    capture_compare_pwm_unit DUT (.*);
    timer_source_model timerModel (.*);
    always #50 ref_clk = ~ref_clk;
    task automatic end_sim();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            end_sim();
        end
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        @(posedge ref_clk);
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask : rdchk
    task automatic preload(input logic [15:0] v);
        {loadValue, load} <= {v, 1'b1};
        @(posedge ref_clk);
        load <= 1'b0;
    endtask : preload
    task automatic pulse(input int idx, input int n);
        repeat (n)
        begin
            capLines[idx] <= 1'b1;
            repeat (4) @(posedge ref_clk);
            capLines[idx] <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : pulse
    task automatic count_high();
        highs = 0;
        repeat (40) @(posedge ref_clk);
        repeat (64)
        begin
            @(negedge ref_clk);
            highs += (channelOut === 1'b1) ? 1 : 0;
        end
        @(posedge ref_clk);
    endtask : count_high
    initial
    begin
        channel_mode_t capMode [4] = '{MODE_CAP_FALL, MODE_CAP_RISE, MODE_CAP_RISE4,
            MODE_CAP_RISE16};
        channel_mode_t cmpMode [4] = '{MODE_CMP_SET, MODE_CMP_CLEAR, MODE_CMP_TOGGLE,
            MODE_CMP_TOGGLE_CLR};
        int            edges [4] = '{1, 1, 4, 16};
        int            sel [4] = '{0, 2, 5, 8};
        int            idx;
        int            n;
        {sys_rst, psel, penable, pwrite, run, load, triggerSelected} = 7'h40;
        {paddr, pwdata, loadValue, capLines, channel_event_enable} = '0;
        periodValue = PERIOD_RESET;
        repeat (4) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        rdchk(OFS_CONTROL, {24'h0, CTL_RESET});
        rdchk(OFS_PERIOD, {24'h0, PERIOD_RESET});
        apb(1'b1, 12'h020, 32'h5a);
        check({31'h0, err}, 32'h1);
        rdchk(12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 4; i++)
        begin
            idx = (sel[i] == 0) ? 0 : sel[i] + 1;
            apb(1'b1, OFS_CONTROL, 32'h0);
            apb(1'b1, OFS_SOURCE, 32'(sel[i]));
            preload(16'hc3a0 + 16'(i));
            apb(1'b1, OFS_CONTROL, {24'h0, 4'h8, capMode[i]});
            apb(1'b1, OFS_FLAG, 32'h1);
            pulse(idx, edges[i] - 1);
            rdchk(OFS_FLAG, 32'h0);
            pulse(idx, 1);
            rdchk(OFS_FLAG, 32'h1);
            rdchk(OFS_PAIR, 32'hc3a0 + 32'(i));
            preload(16'h5a00 + 16'(i));
            pulse(idx, edges[i]);
            rdchk(OFS_PAIR, 32'h5a00 + 32'(i));
            rdchk(OFS_FLAG, 32'h1);
        end
        apb(1'b1, OFS_PAIR, 32'h4000);
        triggerSelected <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            preload(16'h0);
            apb(1'b1, OFS_CONTROL, {24'h0, 4'h8, cmpMode[i]});
            apb(1'b1, OFS_FLAG, 32'h1);
            preload(16'h4000);
            n = 0;
            while (channel_event_flag !== 1'b1 && n < 40)
            begin
                @(negedge ref_clk);
                n++;
            end
            check({31'h0, channel_event_flag}, 32'h1);
            check({31'h0, channelOut}, {31'h0, i % 2 == 0});
            @(posedge ref_clk);
        end
        channel_event_enable <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check({31'h0, wakeRequest}, 32'h1);
        apb(1'b1, OFS_CONTROL, 32'h0);
        check({31'h0, channelOut}, 32'h0);
        periodValue <= 8'h03;
        apb(1'b1, OFS_PERIOD, 32'h3);
        apb(1'b1, OFS_PAIR, 32'h7);
        apb(1'b1, OFS_CONTROL, {24'h0, 4'h8, MODE_PWM});
        preload(16'h0);
        run <= 1'b1;
        count_high();
        check({31'h0, highs >= 24 && highs <= 32}, 32'h1);
        apb(1'b1, OFS_PAIR, 32'h0);
        count_high();
        check(32'(highs), 32'h0);
        end_sim();
    end
endmodule : test_capture_compare_pwm_unit
`default_nettype wire
